// ---- inc/kbi_pkg.sv ----
// Purpose: Shared constants and types for the keyboard level interrupt unit
// Assumes: Special function register bus with 8-bit address and data
// Notes: Offsets are the register addresses on that bus
package kbi_pkg;
    localparam int KBI_LINES = 8;
    localparam logic [7:0] KBI_ADDR_LEVEL_SELECT = 8'h9c;
    localparam logic [7:0] KBI_ADDR_LINE_ENABLE = 8'h9d;
    localparam logic [7:0] KBI_ADDR_LINE_FLAGS = 8'h9e;
    localparam logic [7:0] KBI_RST_LEVEL_SELECT = 8'h00;
    localparam logic [7:0] KBI_RST_LINE_ENABLE = 8'h00;
    localparam logic [7:0] KBI_RST_LINE_FLAGS = 8'h00;

    // One register bus access, carried as a group
    typedef struct packed {
        logic [7:0] addr;
        logic wr;
        logic rd;
        logic [7:0] wdata;
    } kbi_sfr_req_s;

    // Bus access state
    typedef enum logic [1:0] {
        KBI_IDLE = 2'b01,
        KBI_READ = 2'b10
    } kbi_bus_e;
endpackage : kbi_pkg

// ---- verif/kbi_keys.sv ----
// Purpose: Key matrix model on the port pins
// Assumes: A closed key forces its line level
// Notes: No bounce, bench sets levels
`timescale 1ns/100ps
module kbi_keys (
    // Levels asked by the bench
    input wire logic [7:0] key_level,
    // Port pins
    output logic [7:0] keyboard_port
);
    // Switches act at once on the pins
    assign keyboard_port = key_level;
endmodule : kbi_keys

// ---- verif/kbi_tb_top.sv ----
// Purpose: Self-checking bench for the keyboard interrupt unit
// Assumes: Read answers one cycle after the strobe
// Notes: Read data scored through a queue
`timescale 1ns/100ps
module keyboard_level_interrupt_tb_top;
    import kbi_pkg::*;
    logic core_clk = 0, sys_rst = 1, gie = 0, rvalid, irq;
    kbi_sfr_req_s req = '0;
    logic [7:0] rdata, pins, keys = 8'hff, rnd = 8'h02, m, e;
    int error_cnt = 0, n_checks = 0;
    logic [7:0] expq[$];
    kbi_keys kbi_keys_i (.key_level(keys), .keyboard_port(pins));
    kbi_top kbi_top_i (.core_clk(core_clk), .sys_rst(sys_rst),
        .sfr_req(req), .sfr_rdata(rdata), .sfr_rvalid(rvalid),
        .keyboard_global_irq_enable(gie), .keyboard_port(pins),
        .keyboard_irq_request(irq));
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction : lfsr
    // Read data against the oldest queued expectation
    task automatic cmp_rd(input logic [7:0] got, exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %0t rdata %h want %h", $time, got, exp);
        end
    endtask : cmp_rd
    // Interrupt request level
    task automatic cmp_irq(input logic got, exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %0t irq %b want %b", $time, got, exp);
        end
    endtask : cmp_irq
    // One bus access; keys follow a new level select only once it has
    // landed, so old select and new pins never meet and set a stray flag
    task automatic acc(input logic [7:0] a, d, input logic w);
        @(posedge core_clk);
        req <= '{addr: a, wr: w, rd: !w, wdata: d};
        if (!w) expq.push_back(d);
        @(posedge core_clk);
        req <= '0;
        if (w && a == KBI_ADDR_LEVEL_SELECT) keys <= ~d;
    endtask : acc
    task automatic report_and_stop();
        if (expq.size() != 0) begin
            error_cnt++;
            $display("CHECK FAILED %0t %0d reads never answered",
                $time, expq.size());
        end
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : report_and_stop
    initial forever #2.5 core_clk = ~core_clk;
    // Oldest expectation meets each read answer, settled by the low phase
    always @(negedge core_clk)
        if (rvalid === 1'b1) cmp_rd(rdata, expq.pop_front());
    initial begin
        repeat (2) @(posedge core_clk);
        sys_rst <= 1'b0;
        acc(KBI_ADDR_LINE_FLAGS, 8'hff, 1);
        acc(KBI_ADDR_LEVEL_SELECT, KBI_RST_LEVEL_SELECT, 0);
        acc(KBI_ADDR_LINE_ENABLE, KBI_RST_LINE_ENABLE, 0);
        acc(KBI_ADDR_LINE_FLAGS, KBI_RST_LINE_FLAGS, 0);
        acc(8'h9f, 8'h00, 0);
        $display("reset test done");
        for (int i = 0; i < 8; i++) begin
            m = lfsr(rnd);
            e = lfsr(m);
            rnd = lfsr(e);
            acc(KBI_ADDR_LEVEL_SELECT, rnd, 1);
            acc(KBI_ADDR_LINE_ENABLE, e, 1);
            acc(KBI_ADDR_LINE_ENABLE, e, 0);
            keys <= rnd ^ ~m;
            gie <= i[0];
            repeat (3) @(posedge core_clk);
            #1 cmp_irq(irq, (|(m & e)) & i[0]);
            acc(KBI_ADDR_LINE_FLAGS, m, 0);
            keys <= ~rnd;
            repeat (2) @(posedge core_clk);
            acc(KBI_ADDR_LINE_FLAGS, m, 0);
            acc(KBI_ADDR_LINE_FLAGS, 8'h00, 0);
            repeat (2) @(posedge core_clk);
            #1 cmp_irq(irq, 1'b0);
            $display("line test %0d done", i);
        end
        report_and_stop();
    end
    // Watchdog well past the expected run
    initial begin
        #20000;
        error_cnt++;
        report_and_stop();
    end
endmodule : keyboard_level_interrupt_tb_top

// ---- verilog/kbi_top.sv ----
// Purpose: Keyboard level interrupt unit on an 8-bit port
// Assumes: Port inputs synchronous to core_clk; rd and wr one-cycle strobes
// Notes: Read data appears one cycle after the read strobe
// Contract
// [R1] Eight lines, bit n is port line n
// [R2] Flag sets while line at selected level
// [R3] Request when any enabled flag set
// [R4] Reading flag register clears the flags
// [R5] Disabled line never requests an interrupt
// [R6] Select bit 0 low, 1 high level
// [R7] Reset clears flags, enables, level selects
// [R8] All lines share one request, globally gated
// [R9] Match during flag read keeps flag set
`timescale 1ns/100ps
module kbi_top (
    // Clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // Special function register bus
    input wire kbi_pkg::kbi_sfr_req_s sfr_req,
    output logic [7:0] sfr_rdata,
    output logic sfr_rvalid,
    // Global enable from the interrupt enable register
    input wire logic keyboard_global_irq_enable,
    // Keyboard port pins
    input wire logic [7:0] keyboard_port,
    // Interrupt request to the core
    output logic keyboard_irq_request
);
    import kbi_pkg::*;

    // Register state
    logic [7:0] level_select_q;
    logic [7:0] line_enable_q;
    logic [7:0] line_flags_q;
    kbi_bus_e bus_q;

    // Decoded bus and pin terms
    logic [7:0] match;
    logic [2:0] reg_sel;
    logic flag_read;
    logic cfg_write;
    logic any_enabled_flag;

    // Per-line level match, xnor of pin with select bit
    function automatic logic [7:0] level_match(input logic [7:0] pins,
                                               input logic [7:0] sel);
        level_match = ~(pins ^ sel);
    endfunction : level_match

    // One-hot register select: bit 0 level, bit 1 enable, bit 2 flags
    function automatic logic [2:0] reg_decode(input logic [7:0] addr);
        reg_decode = {addr == KBI_ADDR_LINE_FLAGS,
                      addr == KBI_ADDR_LINE_ENABLE,
                      addr == KBI_ADDR_LEVEL_SELECT};
    endfunction : reg_decode

    // Lines never look at a neighbour, so each flag is its own source
    assign match = level_match(keyboard_port, level_select_q); // [R6] [R1]
    assign reg_sel = reg_decode(sfr_req.addr);
    assign flag_read = sfr_req.rd && reg_sel[2];
    assign cfg_write = sfr_req.wr && (reg_sel[0] || reg_sel[1]);
    assign any_enabled_flag = |(line_flags_q & line_enable_q); // [R5]

    // Software-written configuration; the flags have no write path
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            level_select_q <= KBI_RST_LEVEL_SELECT; // [R7]
            line_enable_q <= KBI_RST_LINE_ENABLE; // [R7]
        end else if (cfg_write) begin
            if (reg_sel[0])
                level_select_q <= sfr_req.wdata; // [R6]
            if (reg_sel[1])
                line_enable_q <= sfr_req.wdata; // [R5]
        end
    end

    // Flags: a live match wins over a read clear so no press is lost
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            line_flags_q <= KBI_RST_LINE_FLAGS; // [R7]
        end else if (flag_read) begin
            line_flags_q <= match; // [R4] [R9]
        end else begin
            line_flags_q <= line_flags_q | match; // [R2]
        end
    end

    // Bus state; READ marks the cycle in which read data stands
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            bus_q <= KBI_IDLE;
        end else begin
            case (bus_q)
                KBI_IDLE: bus_q <= sfr_req.rd ? KBI_READ : KBI_IDLE;
                KBI_READ: bus_q <= sfr_req.rd ? KBI_READ : KBI_IDLE;
                default: bus_q <= KBI_IDLE; // Recover from a bad code
            endcase
        end
    end

    // Read strobe answered one cycle later, as a one-cycle pulse
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            sfr_rvalid <= 1'b0;
        end else begin
            sfr_rvalid <= sfr_req.rd;
        end
    end

    // Read data shows the value before the read side effect
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            sfr_rdata <= 8'h00;
        end else if (!sfr_req.rd) begin
            sfr_rdata <= 8'h00; // Quiet bus between reads
        end else begin
            case (sfr_req.addr)
                KBI_ADDR_LEVEL_SELECT: sfr_rdata <= level_select_q;
                KBI_ADDR_LINE_ENABLE: sfr_rdata <= line_enable_q;
                KBI_ADDR_LINE_FLAGS: sfr_rdata <= line_flags_q; // [R4]
                default: sfr_rdata <= 8'h00; // Unmapped reads as zero
            endcase
        end
    end

    // Shared request; registered so it lags the flag by one cycle
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            keyboard_irq_request <= 1'b0;
        end else begin
            keyboard_irq_request <= keyboard_global_irq_enable &&
                any_enabled_flag; // [R3] [R5] [R8]
        end
    end

    // Request checks
    AST_REQ_FOLLOWS_FLAGS: assert property (@(posedge core_clk) // [R3]
        disable iff (sys_rst)
        ##1 keyboard_irq_request == $past(keyboard_global_irq_enable &&
            |(line_flags_q & line_enable_q)))
        else $error("request does not follow enabled flags");
    AST_FLAG_SET_REQUESTS: assert property (@(posedge core_clk) // [R3]
        disable iff (sys_rst)
        (keyboard_global_irq_enable && line_flags_q[1] && line_enable_q[1])
        |=> keyboard_irq_request)
        else $error("enabled flag raised no request");
    AST_REQ_NEEDS_FLAG: assert property (@(posedge core_clk) // [R3]
        disable iff (sys_rst)
        ((line_flags_q & line_enable_q) == 8'h00) |=> !keyboard_irq_request)
        else $error("request without an enabled flag");
    AST_DISABLED_NO_REQ: assert property (@(posedge core_clk) // [R5]
        disable iff (sys_rst)
        (line_enable_q == 8'h00) |=> !keyboard_irq_request)
        else $error("request with all lines disabled");
    AST_GLOBAL_GATE: assert property (@(posedge core_clk) // [R8]
        disable iff (sys_rst)
        !keyboard_global_irq_enable |=> !keyboard_irq_request)
        else $error("request while global enable low");

    // Flag checks; set wins over the read clear
    AST_MATCH_SETS: assert property (@(posedge core_clk) // [R2]
        disable iff (sys_rst)
        (keyboard_port[0] == level_select_q[0]) |=> line_flags_q[0])
        else $error("matching line did not set flag");
    AST_FLAGS_NOT_WRITABLE: assert property (@(posedge core_clk) // [R2]
        disable iff (sys_rst)
        (sfr_req.wr && reg_sel[2] && !sfr_req.rd && match == 8'h00)
        |=> line_flags_q == $past(line_flags_q))
        else $error("flag register changed by a write");
    AST_FLAG_STICKY: assert property (@(posedge core_clk) // [R4]
        disable iff (sys_rst)
        (line_flags_q[5] && !flag_read) |=> line_flags_q[5])
        else $error("flag dropped without read");
    AST_READ_CLEARS: assert property (@(posedge core_clk) // [R4]
        disable iff (sys_rst)
        flag_read |=> line_flags_q == $past(match))
        else $error("flag read did not clear flags");
    AST_READ_KEEPS_EVENT: assert property (@(posedge core_clk) // [R9]
        disable iff (sys_rst)
        (flag_read && match[7]) |=> line_flags_q[7])
        else $error("event lost during flag read");
    AST_NO_CROSSTALK: assert property (@(posedge core_clk) // [R1]
        disable iff (sys_rst)
        (!match[2] && (!line_flags_q[2] || flag_read)) |=> !line_flags_q[2])
        else $error("flag set without its own line matching");

    // Bus checks
    AST_FLAG_READ_DATA: assert property (@(posedge core_clk) // [R4]
        disable iff (sys_rst)
        flag_read |=> sfr_rdata == $past(line_flags_q))
        else $error("flag read returned wrong data");
    AST_RVALID_TRACKS_STATE: assert property (@(posedge core_clk) // [R4]
        disable iff (sys_rst)
        sfr_rvalid == (bus_q == KBI_READ))
        else $error("read valid and bus state disagree");
    AST_SELECT_WRITE_LANDS: assert property (@(posedge core_clk) // [R6]
        disable iff (sys_rst)
        (sfr_req.wr && reg_sel[0])
        |=> level_select_q == $past(sfr_req.wdata))
        else $error("level select write lost");
    AST_ENABLE_WRITE_LANDS: assert property (@(posedge core_clk) // [R5]
        disable iff (sys_rst)
        (sfr_req.wr && reg_sel[1])
        |=> line_enable_q == $past(sfr_req.wdata))
        else $error("line enable write lost");

    // Level checks
    AST_LOW_LEVEL: assert property (@(posedge core_clk) // [R6]
        disable iff (sys_rst)
        (!level_select_q[3] && !keyboard_port[3] && !flag_read)
        |=> line_flags_q[3])
        else $error("low level not detected");
    AST_HIGH_LEVEL: assert property (@(posedge core_clk) // [R6]
        disable iff (sys_rst)
        (level_select_q[4] && keyboard_port[4]) |=> line_flags_q[4])
        else $error("high level not detected");

    // Reset checks; these run while reset is high
    AST_RESET_ZERO: assert property (@(posedge core_clk) // [R7]
        sys_rst |=> (line_flags_q == 8'h00 && line_enable_q == 8'h00 &&
            level_select_q == 8'h00))
        else $error("registers not zero after reset");
    AST_RESET_OUTPUTS: assert property (@(posedge core_clk) // [R7]
        sys_rst |=> (!keyboard_irq_request && !sfr_rvalid &&
            sfr_rdata == 8'h00))
        else $error("outputs not idle after reset");
endmodule : kbi_top
